/* File: sac_pkg.sv */
// Package for the sampling converter start, busy, mode and read control
package sac_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_PS   = 25000;
    localparam int unsigned PWRUP_TIME_PS   = 1000000;
    localparam int unsigned CONV_TIME_PS    = 2300000;
    // Least time rounds up
    localparam int unsigned PWRUP_CYCLES    =
        (PWRUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Longest time rounds down
    localparam int unsigned CONV_CYCLES     = CONV_TIME_PS / CLK_PERIOD_PS;
    localparam int unsigned CNT_W           = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;

    // ==========================================================
    // Widths and layout
    localparam int unsigned RES_W           = 10;
    localparam int unsigned BUS_W           = 8;
    localparam int unsigned LOW_BITS        = 2;
    localparam logic [RES_W-1:0] RES_RST    = 10'h000;
    localparam logic [BUS_W-1:0] BUS_RST    = 8'h00;
    localparam logic [BUS_W-LOW_BITS-1:0] LOW_PAD = 6'h00;

    // ==========================================================
    // Types
    typedef enum logic {
        SAC_MODE_POWER_DOWN,
        SAC_MODE_HIGH_SPEED
    } sac_mode_t;

    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
    } sac_rd_t;

    typedef struct packed {
        logic [BUS_W-1:0] data;
        logic             oe_n;
    } sac_bus_t;
endpackage

/* File: sac_ctrl.sv */
// Convert-start, busy, mode and two-byte read control of the converter
//
// Contract
// - Start rising edge fires 1 us internal pulse
// - Start low at pulse end: convert then
// - Start high at pulse end: wait its fall
// - Gated start is start OR internal pulse
// - Busy high from start through conversion
// - End: track, latch result, busy low
// - Conversion takes about 2.3 us
// - Start high at busy fall: high-speed
// - Start low before busy fall: power-down
// - High-speed: later falling edge starts conversion
// - Read port works while powered down
// - Rising start wakes; pulse holds 1 us
// - Drive bus only when select, read low
// - First read high eight, second low two
// - Low two on bits 7,6, rest zero
// - Further reads alternate high then low
// - Busy rise resets read to high byte
// - No reads while busy; data invalid
// - Start up powered down until rising start
//
// Timing, in clock cycles after a pin change:
//   start pin seen after 2 (synchroniser), rise acted on after 3
//   internal pulse lasts PWRUP_CYCLES, conversion CONV_CYCLES
//   busy rises the cycle after the gated start falls
//   read port drives 3 cycles after select and strobe are both low,
//   and releases 3 cycles after either goes high
// Limitation: a pin level held for less than one clock period may be
// missed by the synchronisers, so the host must hold each level longer
`timescale 1ns/1ps
`default_nettype none

module sac_ctrl
    import sac_pkg::*;
(
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic             i_convert_start_n,
    input  wire logic             i_chip_select_n,
    input  wire logic             i_read_strobe_n,
    input  wire logic [RES_W-1:0] i_sar_result,
    output logic                  o_busy,
    output logic                  o_hold,
    output logic                  o_powered,
    output logic                  o_mode_high_speed,
    output logic [BUS_W-1:0]      o_data_bus,
    output logic                  o_data_bus_oe_n
);

    // ==========================================================
    // Input synchronisers
    // Start pin idles low from power-up, so its synchroniser resets low
    // and no false rising edge follows reset
    logic       start_lvl;
    logic       csel_lvl;
    logic       rd_lvl;
    logic       start_d_r;
    sac_rd_t    rd_pins;

    sac_sync #(
        .RST_VAL (1'b0)
    ) sac_sync_start (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_convert_start_n),
        .o_lvl   (start_lvl)
    );

    sac_sync #(
        .RST_VAL (1'b1)
    ) sac_sync_csel (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_chip_select_n),
        .o_lvl   (csel_lvl)
    );

    sac_sync #(
        .RST_VAL (1'b1)
    ) sac_sync_rd (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_read_strobe_n),
        .o_lvl   (rd_lvl)
    );

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            start_d_r <= 1'b0;
        end else begin
            start_d_r <= start_lvl;
        end
    end

    assign rd_pins.chip_select_n = csel_lvl;
    assign rd_pins.read_strobe_n = rd_lvl;

    wire start_rise = start_lvl & ~start_d_r;

    // ==========================================================
    // Internal power-up pulse and gated start
    logic [CNT_W-1:0] pulse_cnt_r;
    logic [CNT_W-1:0] pulse_cnt_nxt;
    logic             gated_d_r;

    wire pulse_on = (pulse_cnt_r != CNT_ZERO);
    // Restart on every rising edge so the part always gets a full power-up
    assign pulse_cnt_nxt = start_rise ? CNT_W'(PWRUP_CYCLES) :
                           pulse_on   ? pulse_cnt_r - CNT_ONE : CNT_ZERO;
    wire gated     = start_lvl | pulse_on;
    // Falling gated start covers both the pulse end with pin low and a
    // later pin fall, so whichever falls last fixes the sampling instant
    wire gated_fall = gated_d_r & ~gated;

    // ==========================================================
    // Conversion and mode
    logic [CNT_W-1:0] conv_cnt_r;
    logic [CNT_W-1:0] conv_cnt_nxt;
    logic             busy_r;
    logic             hold_r;
    logic             powered_r;
    sac_mode_t        mode_r;
    sac_mode_t        mode_nxt;
    logic [RES_W-1:0] result_r;

    // A start while busy is ignored; the host spaces starts apart
    wire conv_start = gated_fall & ~busy_r & powered_r;
    wire conv_done  = busy_r & (conv_cnt_r == CNT_ONE);
    assign conv_cnt_nxt = conv_start ? CNT_W'(CONV_CYCLES) :
                          busy_r     ? conv_cnt_r - CNT_ONE : CNT_ZERO;
    assign mode_nxt = start_lvl ? SAC_MODE_HIGH_SPEED
                                : SAC_MODE_POWER_DOWN;
    wire powered_nxt = start_rise ? 1'b1 :
                       (conv_done & ~start_lvl) ? 1'b0 : powered_r;

    // Counter restarts on every rise; the gate edge detector trails it
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pulse_cnt_r <= CNT_ZERO;
        end else begin
            pulse_cnt_r <= pulse_cnt_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            gated_d_r <= 1'b0;
        end else begin
            gated_d_r <= gated;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            conv_cnt_r <= CNT_ZERO;
        end else begin
            conv_cnt_r <= conv_cnt_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            powered_r <= 1'b0;
        end else begin
            powered_r <= powered_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            busy_r <= 1'b0;
        end else if (conv_start) begin
            busy_r <= 1'b1;
        end else if (conv_done) begin
            busy_r <= 1'b0;
        end
    end

    // Sampler holds exactly while busy, tracking again at the end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            hold_r <= 1'b0;
        end else if (conv_start) begin
            hold_r <= 1'b1;
        end else if (conv_done) begin
            hold_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mode_r <= SAC_MODE_POWER_DOWN;
        end else if (conv_done) begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            result_r <= RES_RST;
        end else if (conv_done) begin
            result_r <= i_sar_result;
        end
    end

    // ==========================================================
    // Parallel read port
    logic     byte_low_r;
    logic     rd_act_d_r;
    sac_bus_t bus_r;
    sac_bus_t bus_nxt;

    // Port keeps working while powered down: no term on powered_r
    wire rd_active = ~rd_pins.chip_select_n & ~rd_pins.read_strobe_n;
    wire rd_end    = rd_act_d_r & ~rd_active;
    wire [BUS_W-1:0] hi_byte = result_r[RES_W-1 -: BUS_W];
    wire [BUS_W-1:0] lo_byte = {result_r[LOW_BITS-1:0], LOW_PAD};

    assign bus_nxt.data = !rd_active ? BUS_RST :
                          byte_low_r ? lo_byte : hi_byte;
    assign bus_nxt.oe_n = ~rd_active;

    // Busy rise wins over a read ending in the same cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            byte_low_r <= 1'b0;
        end else if (conv_start) begin
            byte_low_r <= 1'b0;
        end else if (rd_end) begin
            byte_low_r <= ~byte_low_r;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rd_act_d_r <= 1'b0;
        end else begin
            rd_act_d_r <= rd_active;
        end
    end

    // Reads during busy are served, but the data then has no meaning
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            bus_r <= '{data: BUS_RST, oe_n: 1'b1};
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign o_busy            = busy_r;
    assign o_hold            = hold_r;
    assign o_powered         = powered_r;
    assign o_mode_high_speed = (mode_r == SAC_MODE_HIGH_SPEED);
    assign o_data_bus        = bus_r.data;
    assign o_data_bus_oe_n   = bus_r.oe_n;

endmodule

// ==========================================================
// Two-flip-flop synchroniser for one asynchronous pin
module sac_sync
    import sac_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_pin,
    output logic      o_lvl
);

    // Only the second stage is read outside, so a metastable first
    // stage gets a full cycle to settle
    logic meta_r;
    logic sync_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
        end
    end

    assign o_lvl = sync_r;

endmodule

`default_nettype wire

/* File: sac_chk.sv */
// Assertion checker on the converter control ports
`timescale 1ns/1ps
`default_nettype none
module sac_chk
    import sac_pkg::*;
(
    input wire logic             i_mclk,
    input wire logic             i_rst_n,
    input wire logic             i_convert_start_n,
    input wire logic             i_chip_select_n,
    input wire logic             i_read_strobe_n,
    input wire logic [RES_W-1:0] i_sar_result,
    input wire logic             o_busy,
    input wire logic             o_hold,
    input wire logic             o_powered,
    input wire logic             o_mode_high_speed,
    input wire logic [BUS_W-1:0] o_data_bus,
    input wire logic             o_data_bus_oe_n
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // Properties
    sequence s_run; ##91 o_busy ##1 !o_busy; endsequence
    sequence s_end; $fell(o_busy); endsequence
    property p_run; $rose(o_busy) |-> s_run; endproperty
    property p_hold; o_hold == o_busy; endproperty
    property p_wake; $rose(o_busy) |-> $past(o_powered, 38); endproperty
    property p_hs; s_end ##0 $past(i_convert_start_n, 4) |-> ##[0:1] o_mode_high_speed;
    endproperty
    property p_pd; s_end ##0 !$past(i_convert_start_n, 4) |->
        ##[0:1] !(o_mode_high_speed || o_powered);
    endproperty
    property p_keep; $changed(o_mode_high_speed) |-> $past(o_busy) || $past(o_busy, 2); endproperty
    property p_oe; !o_data_bus_oe_n |-> !($past(i_chip_select_n, 3) || $past(i_read_strobe_n, 3));
    endproperty
    property p_rel; o_data_bus_oe_n |-> o_data_bus == BUS_RST; endproperty
    a_run: assert property (p_run) else $error("busy length wrong");
    a_hold: assert property (p_hold) else $error("hold differs from busy");
    a_wake: assert property (p_wake) else $error("conversion before power-up");
    a_hs: assert property (p_hs) else $error("high-speed mode missed");
    a_pd: assert property (p_pd) else $error("power-down missed");
    a_keep: assert property (p_keep) else $error("mode moved outside busy fall");
    a_oe: assert property (p_oe) else $error("bus driven without read");
    a_rel: assert property (p_rel) else $error("released bus not zero");
endmodule
bind sac_ctrl sac_chk sac_chk_inst (.*);
`default_nettype wire

/* File: sac_host.sv */
// Host model that performs one strobed read per request
`timescale 1ns/1ps
`default_nettype none
module sac_host
    import sac_pkg::*;
#(parameter int HOLD = 6)
(
    input  wire logic             i_mclk,
    input  wire logic             i_req,
    input  wire logic [BUS_W-1:0] i_bus,
    output var sac_rd_t           o_rd,
    output logic [BUS_W-1:0]      o_rdata,
    output logic                  o_ack
);
    int cnt = 0;
    initial o_rd = '1;
    initial o_ack = 1'b0;
    initial o_rdata = BUS_RST;
    // Strobe held long enough for the synchronised bus to settle
    always @(posedge i_mclk) begin
        o_ack <= 1'b0;
        cnt <= o_rd.read_strobe_n ? 0 : cnt + 1;
        if (i_req && o_rd.read_strobe_n)
            o_rd <= '0;
        if (!o_rd.read_strobe_n && cnt == HOLD) begin
            o_rdata <= i_bus;
            o_rd <= '1;
            o_ack <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sac_pkg::*;
    typedef struct {logic [RES_W-1:0] res; logic hs; logic late;} sac_row_t;
    sac_row_t rows [4] = '{'{10'h3FF, 1'b0, 1'b0}, '{10'h2A5, 1'b1, 1'b1},
                          '{10'h001, 1'b1, 1'b0}, '{10'h15A, 1'b0, 1'b1}};
    logic mclk = 0, rst_n = 0, cvs_n = 0, req = 0, busy, hold, pwr, hs, oe_n, ack;
    logic [RES_W-1:0] res = RES_RST;
    logic [BUS_W-1:0] bus, rdata;
    sac_rd_t rd;
    int n_fail = 0, num_checks = 0;
    sac_ctrl sac_ctrl_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_convert_start_n(cvs_n),
        .i_chip_select_n(rd.chip_select_n), .i_read_strobe_n(rd.read_strobe_n),
        .i_sar_result(res), .o_busy(busy), .o_hold(hold), .o_powered(pwr),
        .o_mode_high_speed(hs), .o_data_bus(bus), .o_data_bus_oe_n(oe_n));
    sac_host sac_host_inst (.i_mclk(mclk), .i_req(req), .i_bus(bus), .o_rd(rd),
        .o_rdata(rdata), .o_ack(ack));
    initial forever #12.5 mclk = ~mclk;
    task automatic chk(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 300 && busy !== lvl; i++) @(posedge mclk);
        if (busy !== lvl) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic rd_chk(input logic [BUS_W-1:0] exp);
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        for (int i = 0; i < 30 && ack !== 1'b1; i++) @(posedge mclk);
        if (ack !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        chk(rdata, exp);
        repeat (4) @(posedge mclk);
    endtask
    task automatic conv(input logic hs_m, input logic late);
        cvs_n <= 1'b1;
        repeat (late ? 50 : 2) @(posedge mclk);
        cvs_n <= 1'b0;
        wait_busy(1'b1);
        cvs_n <= hs_m;
        wait_busy(1'b0);
        repeat (3) @(posedge mclk);
        chk(BUS_W'(hs), BUS_W'(hs_m));
        chk(BUS_W'(pwr), BUS_W'(hs_m));
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        chk({busy, hold, pwr, hs, oe_n, 3'h0}, 8'h08);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            res <= rows[i].res;
            conv(rows[i].hs, rows[i].late);
            rd_chk(rows[i].res[9:2]);
            rd_chk({rows[i].res[1:0], LOW_PAD});
            rd_chk(rows[i].res[9:2]);
            $display("row %0d done", i);
        end
        // Reset landing in mid-conversion must drop busy and power
        cvs_n <= 1'b1;
        repeat (2) @(posedge mclk);
        cvs_n <= 1'b0;
        wait_busy(1'b1);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({4'h0, busy, hold, pwr, oe_n}, 8'h01);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({4'h0, busy, hold, pwr, oe_n}, 8'h01);
        res <= 10'h2C3;
        conv(1'b0, 1'b0);
        rd_chk(8'hB0);
        $display("reset test done");
        end_of_test();
    end
endmodule
`default_nettype wire
